// ---- src/nvm_prot_cfg.svh ----
// Purpose: constants for the nvm fault status and protection block
// Assumes: register indices are word indices; byte address is four times the index
// Notes:   all offsets, fields, reset values and sizes live here as macros
//
// Summary of operation
// (R1) double-bit ecc fault or read/command collision sets the double fault flag
// (R2) double fault flag clears only by writing one; zero leaves it alone
// (R3) with ignore bit clear, corrected single fault or collision sets single fault flag
// (R4) single fault flag clears only by writing one; zero leaves it alone
// (R5) parity errors set exactly one flag; both flags together mean a collision
// (R6) fault flags are stored one cycle after the array read
// (R7) reset sequence loads flash protection from the nonvolatile flash protection byte
// (R8) flash protection writes accepted only when the protected region does not shrink
// (R9) program or erase into protected flash or eeprom refused, violation flag set
// (R10) flash block erase refused while any flash sector in it is protected
// (R11) eeprom block erase refused while any eeprom sector is protected
// (R12) operation bit selects whether range bits define protected or unprotected ranges
// (R13) high range disable bit zero enables the region ending at the top address
// (R14) high range size field writable only while high range disable is set
// (R15) flash protection bit six reads one; other reserved bits read zero
// (R16) eeprom protection size may only grow while control is zero; control bit only goes one to zero
// (R17) eeprom control zero protects range sized by size field; one turns it off
// (R18) reset sequence loads eeprom control and size from the nonvolatile eeprom byte
// (R19) software unprotects the sector holding a protection byte before reprogramming it
// (R20) violation flag clears by writing one; while set, no command may launch
// (R21) fault status bits seven to two read zero; reset clears both fault flags
`ifndef NVM_PROT_CFG_SVH
`define NVM_PROT_CFG_SVH

`define REG_ADDR_W          8
`define IDX_NVM_CONFIG      8'h04
`define IDX_CMD_STATUS      8'h05
`define IDX_ECC_FAULT       8'h07
`define IDX_FLASH_PROT      8'h08
`define IDX_EEPROM_PROT     8'h09

`define BIT_IGNORE_SINGLE   0
`define BIT_PROT_VIOL       4
`define BIT_DOUBLE_FAULT    1
`define BIT_SINGLE_FAULT    0
`define BIT_FLASH_PROT_OP   7
`define BIT_FLASH_RSVD_ONE  6
`define BIT_HIGH_DISABLE    5
`define BIT_HIGH_SIZE_HI    4
`define BIT_HIGH_SIZE_LO    3
`define BIT_EEPROM_CTRL     7
`define BIT_EEPROM_SIZE_HI  1
`define BIT_EEPROM_SIZE_LO  0

`define FLASH_PROT_RST      8'h60
`define EEPROM_PROT_RST     8'h80
`define FLASH_TOP_ADDR      16'hffff
`define FLASH_BASE_ADDR     16'hc000
`define HIGH_UNIT_SIZE      17'h00200
`define EEPROM_UNIT_SIZE    16'h0020

`define AXI_RESP_OKAY       2'b00
`define AXI_RESP_SLVERR     2'b10

`endif

// ---- src/nvm_prot_pkg.sv ----
// Purpose: shared types and decode helpers for the nvm protection block
// Assumes: constants come from nvm_prot_cfg.svh
// Notes:   byte address of a register is its index times four
package nvm_prot_pkg;
  `include "nvm_prot_cfg.svh"

  typedef struct packed {
    logic                    en;
    logic [`REG_ADDR_W-1:0]  addr;
    logic [7:0]              data;
    logic                    lane0;
  } reg_wr_t;

  typedef struct packed {
    logic valid;
    logic single_fault;
    logic double_fault;
    logic collision;
  } array_read_t;

  typedef struct packed {
    logic        valid;
    logic        block_erase;
    logic        eeprom;
    logic [15:0] addr;
  } cmd_req_t;

  typedef struct packed {
    logic       prot_op;
    logic       high_disable;
    logic [1:0] high_size;
  } flash_prot_t;

  typedef struct packed {
    logic       control;
    logic [1:0] size;
  } eeprom_prot_t;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_CONFIG,
    REG_CMD_STATUS,
    REG_ECC_FAULT,
    REG_FLASH_PROT,
    REG_EEPROM_PROT
  } reg_sel_t;

  function automatic logic [`REG_ADDR_W-1:0] idx_addr(input logic [7:0] idx);
    idx_addr = {idx[`REG_ADDR_W-3:0], 2'b00};
  endfunction

  function automatic reg_sel_t decode_reg(input logic [`REG_ADDR_W-1:0] a);
    if (a == idx_addr(`IDX_NVM_CONFIG))       decode_reg = REG_CONFIG;
    else if (a == idx_addr(`IDX_CMD_STATUS))  decode_reg = REG_CMD_STATUS;
    else if (a == idx_addr(`IDX_ECC_FAULT))   decode_reg = REG_ECC_FAULT;
    else if (a == idx_addr(`IDX_FLASH_PROT))  decode_reg = REG_FLASH_PROT;
    else if (a == idx_addr(`IDX_EEPROM_PROT)) decode_reg = REG_EEPROM_PROT;
    else                                      decode_reg = REG_NONE;
  endfunction

  function automatic logic [16:0] high_region_size(input logic [1:0] hs);
    high_region_size = `HIGH_UNIT_SIZE << hs;
  endfunction

  // amount of flash under protection, used to forbid shrinking writes
  function automatic logic [16:0] flash_prot_amount(input flash_prot_t p);
    logic [16:0] total;
    total = 17'(`FLASH_TOP_ADDR) - 17'(`FLASH_BASE_ADDR) + 17'h00001;
    if (p.prot_op)
      flash_prot_amount = p.high_disable ? 17'h00000 : high_region_size(p.high_size);
    else
      flash_prot_amount = p.high_disable ? total : total - high_region_size(p.high_size);
  endfunction
endpackage

// ---- src/axil_reg_port.sv ----
// Purpose: axi4-lite slave front end for the byte-wide register file
// Assumes: one write and one read outstanding at a time
// Notes:   address and data may arrive in either order; unmapped answers slverr
`timescale 1ns/1ps
module axil_reg_port
  import nvm_prot_pkg::*;
(
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  input  wire logic [`REG_ADDR_W-1:0] awaddr_i,
  input  wire logic                   awvalid_i,
  output logic                        awready_o,
  input  wire logic [31:0]            wdata_i,
  input  wire logic [3:0]             wstrb_i,
  input  wire logic                   wvalid_i,
  output logic                        wready_o,
  output logic [1:0]                  bresp_o,
  output logic                        bvalid_o,
  input  wire logic                   bready_i,
  input  wire logic [`REG_ADDR_W-1:0] araddr_i,
  input  wire logic                   arvalid_i,
  output logic                        arready_o,
  output logic [31:0]                 rdata_o,
  output logic [1:0]                  rresp_o,
  output logic                        rvalid_o,
  input  wire logic                   rready_i,
  output reg_wr_t                     wr_o,
  output logic [`REG_ADDR_W-1:0]      rd_addr_o,
  input  wire logic [7:0]             rd_data_i
);
  logic                   aw_held_r;
  logic [`REG_ADDR_W-1:0] aw_addr_r;
  logic                   w_held_r;
  logic [7:0]             w_data_r;
  logic                   w_lane0_r;
  logic                   bvalid_r;
  logic [1:0]             bresp_r;
  logic                   rvalid_r;
  logic [31:0]            rdata_r;
  logic [1:0]             rresp_r;
  logic                   wr_fire;

  assign awready_o = !aw_held_r && !bvalid_r;
  assign wready_o  = !w_held_r && !bvalid_r;
  assign arready_o = !rvalid_r;
  assign wr_fire   = aw_held_r && w_held_r && !bvalid_r;
  assign bvalid_o  = bvalid_r;
  assign bresp_o   = bresp_r;
  assign rvalid_o  = rvalid_r;
  assign rdata_o   = rdata_r;
  assign rresp_o   = rresp_r;
  assign rd_addr_o = araddr_i;

  always_comb begin
    wr_o.en    = wr_fire && (decode_reg(aw_addr_r) != REG_NONE);
    wr_o.addr  = aw_addr_r;
    wr_o.data  = w_data_r;
    wr_o.lane0 = w_lane0_r;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r  <= 1'b0;
      w_data_r  <= 8'h00;
      w_lane0_r <= 1'b0;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= awaddr_i;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        w_held_r  <= 1'b1;
        w_data_r  <= wdata_i[7:0];
        w_lane0_r <= wstrb_i[0];
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `AXI_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (decode_reg(aw_addr_r) == REG_NONE) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
    end else if (bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= `AXI_RESP_OKAY;
    end else if (arvalid_i && arready_o) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h00_0000, rd_data_i};
      rresp_r  <= (decode_reg(araddr_i) == REG_NONE) ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
    end else if (rready_i) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule

// ---- src/prot_range_check.sv ----
// Purpose: decides whether a program or erase target is protected
// Assumes: flash addresses are global 16-bit, eeprom addresses are offsets
// Notes:   purely combinational; the low flash range is not modelled
`timescale 1ns/1ps
module prot_range_check
  import nvm_prot_pkg::*;
(
  input  wire flash_prot_t  flash_i,
  input  wire eeprom_prot_t eeprom_i,
  input  wire cmd_req_t     cmd_i,
  output logic              protected_o
);
  logic [16:0] high_lo;
  logic        in_high;
  logic        flash_sector_prot;
  logic        flash_any_prot;
  logic        ee_sector_prot;
  logic [16:0] ee_size;

  always_comb begin
    high_lo = 17'(`FLASH_TOP_ADDR) + 17'h00001 - high_region_size(flash_i.high_size);
    in_high = {1'b0, cmd_i.addr} >= high_lo;
    // high range only counts while its disable bit is zero
    if (flash_i.prot_op) begin // R12
      flash_sector_prot = !flash_i.high_disable && in_high; // R13
      flash_any_prot    = !flash_i.high_disable;
    end else begin
      flash_sector_prot = !(!flash_i.high_disable && in_high); // R13
      flash_any_prot    = 1'b1;
    end
    ee_size        = 17'({`EEPROM_UNIT_SIZE} << eeprom_i.size);
    ee_sector_prot = !eeprom_i.control && ({1'b0, cmd_i.addr} < ee_size); // R17
    if (cmd_i.eeprom)
      protected_o = cmd_i.block_erase ? !eeprom_i.control : ee_sector_prot; // R11
    else
      protected_o = cmd_i.block_erase ? flash_any_prot : flash_sector_prot; // R10
  end
endmodule

// ---- src/nvm_fault_status_and_protection.sv ----
// Purpose: ecc fault status, command protection check and protection registers
// Assumes: array read reports and command requests come from logic on clock_i
// Notes:   registers are reached over axi4-lite, one byte per aligned word
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
module nvm_fault_status_and_protection
  import nvm_prot_pkg::*;
(
  input  wire logic                   clock_i,
  input  wire logic                   rst_n_i,
  input  wire logic [`REG_ADDR_W-1:0] s_axil_awaddr_i,
  input  wire logic                   s_axil_awvalid_i,
  output logic                        s_axil_awready_o,
  input  wire logic [31:0]            s_axil_wdata_i,
  input  wire logic [3:0]             s_axil_wstrb_i,
  input  wire logic                   s_axil_wvalid_i,
  output logic                        s_axil_wready_o,
  output logic [1:0]                  s_axil_bresp_o,
  output logic                        s_axil_bvalid_o,
  input  wire logic                   s_axil_bready_i,
  input  wire logic [`REG_ADDR_W-1:0] s_axil_araddr_i,
  input  wire logic                   s_axil_arvalid_i,
  output logic                        s_axil_arready_o,
  output logic [31:0]                 s_axil_rdata_o,
  output logic [1:0]                  s_axil_rresp_o,
  output logic                        s_axil_rvalid_o,
  input  wire logic                   s_axil_rready_i,
  input  wire array_read_t            array_read_i,
  input  wire logic                   nv_load_i,
  input  wire logic [7:0]             nv_flash_prot_byte_i,
  input  wire logic [7:0]             nv_eeprom_prot_byte_i,
  input  wire cmd_req_t               cmd_i,
  output logic                        cmd_accept_o,
  output logic                        cmd_refuse_o,
  output logic                        cmd_seq_blocked_o,
  output logic                        double_fault_flag_o,
  output logic                        single_fault_flag_o
);
  logic         rst_meta_r;
  logic         rst_sync_r;
  reg_wr_t      wr;
  logic [`REG_ADDR_W-1:0] rd_addr;
  logic [7:0]   rd_data;
  reg_sel_t     wr_sel;

  logic         ignore_single_fault_r;
  array_read_t  read_stage_r;
  logic         double_fault_flag_r;
  logic         single_fault_flag_r;
  logic         double_fault_nxt;
  logic         single_fault_nxt;
  logic         set_double;
  logic         set_single;
  logic         protection_violation_flag_r;
  logic         protection_violation_nxt;

  flash_prot_t  flash_prot_r;
  flash_prot_t  flash_prot_nxt;
  flash_prot_t  flash_wr_req;
  eeprom_prot_t eeprom_prot_r;
  eeprom_prot_t eeprom_prot_nxt;

  logic         target_protected;
  logic         cmd_refused;
  logic         cmd_blocked;
  logic         clr_wr_en;

  // reset is asserted at once but released in step with the clock
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  axil_reg_port u_port (
    .clock_i   (clock_i),
    .rst_n_i   (rst_sync_r),
    .awaddr_i  (s_axil_awaddr_i),
    .awvalid_i (s_axil_awvalid_i),
    .awready_o (s_axil_awready_o),
    .wdata_i   (s_axil_wdata_i),
    .wstrb_i   (s_axil_wstrb_i),
    .wvalid_i  (s_axil_wvalid_i),
    .wready_o  (s_axil_wready_o),
    .bresp_o   (s_axil_bresp_o),
    .bvalid_o  (s_axil_bvalid_o),
    .bready_i  (s_axil_bready_i),
    .araddr_i  (s_axil_araddr_i),
    .arvalid_i (s_axil_arvalid_i),
    .arready_o (s_axil_arready_o),
    .rdata_o   (s_axil_rdata_o),
    .rresp_o   (s_axil_rresp_o),
    .rvalid_o  (s_axil_rvalid_o),
    .rready_i  (s_axil_rready_i),
    .wr_o      (wr),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data)
  );

  prot_range_check u_check (
    .flash_i     (flash_prot_r),
    .eeprom_i    (eeprom_prot_r),
    .cmd_i       (cmd_i),
    .protected_o (target_protected)
  );

  // only byte lane 0 carries register bits; other lanes are ignored
  assign clr_wr_en = wr.en && wr.lane0;
  assign wr_sel    = decode_reg(wr.addr);

  always_comb begin
    rd_data = 8'h00;
    case (decode_reg(rd_addr))
      REG_CONFIG: begin
        rd_data[`BIT_IGNORE_SINGLE] = ignore_single_fault_r;
      end
      REG_CMD_STATUS: begin
        rd_data[`BIT_PROT_VIOL] = protection_violation_flag_r;
      end
      REG_ECC_FAULT: begin
        rd_data[`BIT_DOUBLE_FAULT] = double_fault_flag_r; // R21
        rd_data[`BIT_SINGLE_FAULT] = single_fault_flag_r;
      end
      REG_FLASH_PROT: begin
        rd_data[`BIT_FLASH_PROT_OP]                      = flash_prot_r.prot_op;
        rd_data[`BIT_FLASH_RSVD_ONE]                     = 1'b1; // R15
        rd_data[`BIT_HIGH_DISABLE]                       = flash_prot_r.high_disable;
        rd_data[`BIT_HIGH_SIZE_HI:`BIT_HIGH_SIZE_LO]     = flash_prot_r.high_size;
      end
      REG_EEPROM_PROT: begin
        rd_data[`BIT_EEPROM_CTRL]                        = eeprom_prot_r.control;
        rd_data[`BIT_EEPROM_SIZE_HI:`BIT_EEPROM_SIZE_LO] = eeprom_prot_r.size;
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ignore_single_fault_r <= 1'b0;
    end else if (clr_wr_en && wr_sel == REG_CONFIG) begin
      ignore_single_fault_r <= wr.data[`BIT_IGNORE_SINGLE];
    end
  end

  // one stage between the read report and the flags
  always_ff @(posedge clock_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      read_stage_r <= '0;
    end else begin
      read_stage_r <= array_read_i; // R6
    end
  end

  always_comb begin
    set_double = 1'b0;
    set_single = 1'b0;
    if (read_stage_r.valid) begin
      if (read_stage_r.collision) begin
        set_double = 1'b1; // R1 R5
        set_single = !ignore_single_fault_r; // R3 R5
      end else if (read_stage_r.double_fault) begin
        set_double = 1'b1; // R1 R5
      end else if (read_stage_r.single_fault) begin
        set_single = !ignore_single_fault_r; // R3
      end
    end
  end

  // a fault landing in the clearing cycle survives the clear
  always_comb begin
    double_fault_nxt = double_fault_flag_r;
    single_fault_nxt = single_fault_flag_r;
    if (clr_wr_en && wr_sel == REG_ECC_FAULT) begin
      if (wr.data[`BIT_DOUBLE_FAULT])
        double_fault_nxt = 1'b0; // R2
      if (wr.data[`BIT_SINGLE_FAULT])
        single_fault_nxt = 1'b0; // R4
    end
    if (set_double)
      double_fault_nxt = 1'b1;
    if (set_single)
      single_fault_nxt = 1'b1;
  end

  always_ff @(posedge clock_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      double_fault_flag_r <= 1'b0; // R21
      single_fault_flag_r <= 1'b0; // R21
    end else begin
      double_fault_flag_r <= double_fault_nxt;
      single_fault_flag_r <= single_fault_nxt;
    end
  end

  assign double_fault_flag_o = double_fault_flag_r;
  assign single_fault_flag_o = single_fault_flag_r;

  // command gate: a pending violation blocks every launch
  assign cmd_blocked       = protection_violation_flag_r; // R20
  assign cmd_refused       = cmd_i.valid && !cmd_blocked && target_protected; // R9
  assign cmd_accept_o      = cmd_i.valid && !cmd_blocked && !target_protected;
  assign cmd_refuse_o      = cmd_i.valid && (cmd_blocked || target_protected);
  assign cmd_seq_blocked_o = cmd_blocked; // R20

  always_comb begin
    protection_violation_nxt = protection_violation_flag_r;
    if (clr_wr_en && wr_sel == REG_CMD_STATUS && wr.data[`BIT_PROT_VIOL])
      protection_violation_nxt = 1'b0; // R20
    if (cmd_refused)
      protection_violation_nxt = 1'b1; // R9
  end

  always_ff @(posedge clock_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      protection_violation_flag_r <= 1'b0;
    end else begin
      protection_violation_flag_r <= protection_violation_nxt;
    end
  end

  // size bits only move while the high range is switched off
  always_comb begin
    flash_wr_req.prot_op      = wr.data[`BIT_FLASH_PROT_OP];
    flash_wr_req.high_disable = wr.data[`BIT_HIGH_DISABLE];
    flash_wr_req.high_size    = flash_prot_r.high_disable ? // R14
                                wr.data[`BIT_HIGH_SIZE_HI:`BIT_HIGH_SIZE_LO] :
                                flash_prot_r.high_size;
    flash_prot_nxt = flash_prot_r;
    if (nv_load_i) begin
      flash_prot_nxt.prot_op      = nv_flash_prot_byte_i[`BIT_FLASH_PROT_OP]; // R7
      flash_prot_nxt.high_disable = nv_flash_prot_byte_i[`BIT_HIGH_DISABLE];
      flash_prot_nxt.high_size    = nv_flash_prot_byte_i[`BIT_HIGH_SIZE_HI:`BIT_HIGH_SIZE_LO];
    end else if (clr_wr_en && wr_sel == REG_FLASH_PROT &&
                 flash_prot_amount(flash_wr_req) >= flash_prot_amount(flash_prot_r)) begin
      flash_prot_nxt = flash_wr_req; // R8
    end
  end

  // control bit only falls; size only grows while protection is on
  always_comb begin
    eeprom_prot_nxt = eeprom_prot_r;
    if (nv_load_i) begin
      eeprom_prot_nxt.control = nv_eeprom_prot_byte_i[`BIT_EEPROM_CTRL]; // R18
      eeprom_prot_nxt.size    = nv_eeprom_prot_byte_i[`BIT_EEPROM_SIZE_HI:`BIT_EEPROM_SIZE_LO];
    end else if (clr_wr_en && wr_sel == REG_EEPROM_PROT) begin
      eeprom_prot_nxt.control = eeprom_prot_r.control & wr.data[`BIT_EEPROM_CTRL]; // R16
      if (eeprom_prot_r.control ||
          wr.data[`BIT_EEPROM_SIZE_HI:`BIT_EEPROM_SIZE_LO] > eeprom_prot_r.size)
        eeprom_prot_nxt.size = wr.data[`BIT_EEPROM_SIZE_HI:`BIT_EEPROM_SIZE_LO]; // R16
    end
  end

  always_ff @(posedge clock_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      flash_prot_r.prot_op      <= 1'(`FLASH_PROT_RST >> `BIT_FLASH_PROT_OP);
      flash_prot_r.high_disable <= 1'b1;
      flash_prot_r.high_size    <= 2'h0;
      eeprom_prot_r.control     <= 1'b1;
      eeprom_prot_r.size        <= 2'h0;
    end else begin
      flash_prot_r  <= flash_prot_nxt;
      eeprom_prot_r <= eeprom_prot_nxt;
    end
  end
endmodule

// ---- testbench/nvm_fault_status_and_protection_sva.sv ----
// Purpose: fault flag and command gate checks
// Assumes: flags land one edge after the staged report
// Notes:   bound to the top
`timescale 1ns/1ps
module nvm_fps_sva
  import nvm_prot_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        s_axil_wvalid_i,
  input wire array_read_t array_read_i,
  input wire cmd_req_t    cmd_i,
  input wire logic        cmd_accept_o,
  input wire logic        cmd_refuse_o,
  input wire logic        cmd_seq_blocked_o,
  input wire logic        double_fault_flag_o,
  input wire logic        single_fault_flag_o
);
  array_read_t d1_r, d2_r;
  // report delayed to the edge its flag shows
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      d1_r <= '0;
      d2_r <= '0;
    end else begin
      d1_r <= array_read_i;
      d2_r <= d1_r;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_dbl_rise;
    $rose(double_fault_flag_o) |-> d2_r.valid && (d2_r.double_fault || d2_r.collision);
  endproperty
  a_dbl_rise: assert property (p_dbl_rise)
    else $error("double flag without cause");
  property p_sgl_rise;
    $rose(single_fault_flag_o) |-> d2_r.valid && (d2_r.single_fault || d2_r.collision);
  endproperty
  a_sgl_rise: assert property (p_sgl_rise)
    else $error("single flag without cause");
  property p_both;
    $rose(single_fault_flag_o) && $rose(double_fault_flag_o) |-> d2_r.collision;
  endproperty
  a_both: assert property (p_both)
    else $error("both flags without collision");
  property p_dbl_late;
    d1_r.valid && d1_r.double_fault |=> double_fault_flag_o;
  endproperty
  a_dbl_late: assert property (p_dbl_late)
    else $error("double flag late");
  property p_dbl_hold;
    $fell(double_fault_flag_o) |-> $past(s_axil_wvalid_i, 2) || $past(s_axil_wvalid_i, 3);
  endproperty
  a_dbl_hold: assert property (p_dbl_hold)
    else $error("double flag cleared unasked");
  property p_sgl_hold;
    $fell(single_fault_flag_o) |-> $past(s_axil_wvalid_i, 2) || $past(s_axil_wvalid_i, 3);
  endproperty
  a_sgl_hold: assert property (p_sgl_hold)
    else $error("single flag cleared unasked");
  property p_viol_set;
    cmd_refuse_o && !cmd_seq_blocked_o |=> cmd_seq_blocked_o;
  endproperty
  a_viol_set: assert property (p_viol_set)
    else $error("no violation after refusal");
  property p_blocked;
    cmd_seq_blocked_o && cmd_i.valid |-> cmd_refuse_o && !cmd_accept_o;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("accept while blocked");
endmodule

bind nvm_fault_status_and_protection nvm_fps_sva u_sva (.*);

// ---- testbench/nvm_fault_status_and_protection_tb.sv ----
// Purpose: self-checking bench
// Assumes: inputs change after rising edges
// Notes:   protection bytes enter by load pulse
`timescale 1ns/1ps
`include "nvm_prot_cfg.svh"
module nvm_fault_status_and_protection_tb
  import nvm_prot_pkg::*;
;
  localparam logic [7:0] A_CFG = `IDX_NVM_CONFIG << 2;
  localparam logic [7:0] A_ST  = `IDX_CMD_STATUS << 2;
  localparam logic [7:0] A_ECC = `IDX_ECC_FAULT << 2;
  localparam logic [7:0] A_FP  = `IDX_FLASH_PROT << 2;
  localparam logic [7:0] A_EP  = `IDX_EEPROM_PROT << 2;
  logic        clock_i, rst_n_i, nv_load_i, cmd_accept_o, cmd_refuse_o, cmd_seq_blocked_o;
  logic        s_axil_awvalid_i, s_axil_awready_o, s_axil_wvalid_i, s_axil_wready_o;
  logic        s_axil_bvalid_o, s_axil_bready_i, s_axil_arvalid_i, s_axil_arready_o;
  logic        s_axil_rvalid_o, s_axil_rready_i, double_fault_flag_o, single_fault_flag_o;
  logic [7:0]  s_axil_awaddr_i, s_axil_araddr_i, nv_flash_prot_byte_i, nv_eeprom_prot_byte_i;
  logic [31:0] s_axil_wdata_i, s_axil_rdata_o;
  logic [3:0]  s_axil_wstrb_i;
  logic [1:0]  s_axil_bresp_o, s_axil_rresp_o;
  array_read_t array_read_i;
  cmd_req_t    cmd_i;
  int          error_cnt, n_compared, cyc;

  nvm_fault_status_and_protection uut (.*);

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock_i);
    {s_axil_awaddr_i, s_axil_wdata_i} <= {a, 24'h0, d};
    {s_axil_awvalid_i, s_axil_wvalid_i, s_axil_bready_i} <= 3'b111;
    do begin
      @(posedge clock_i);
      if (s_axil_awready_o) s_axil_awvalid_i <= 1'b0;
      if (s_axil_wready_o) s_axil_wvalid_i <= 1'b0;
    end while (!s_axil_bvalid_o);
    s_axil_bready_i <= 1'b0;
    chk(32'(s_axil_bresp_o), 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, e, input logic [1:0] er = 2'b00);
    @(posedge clock_i);
    s_axil_araddr_i <= a;
    {s_axil_arvalid_i, s_axil_rready_i} <= 2'b11;
    do begin
      @(posedge clock_i);
      if (s_axil_arready_o) s_axil_arvalid_i <= 1'b0;
    end while (!s_axil_rvalid_o);
    s_axil_rready_i <= 1'b0;
    chk(s_axil_rdata_o, {24'h0, e});
    chk(32'(s_axil_rresp_o), 32'(er));
  endtask
  task automatic arr(input logic [2:0] k);
    @(posedge clock_i);
    array_read_i <= {1'b1, k};
    @(posedge clock_i);
    array_read_i <= '0;
  endtask
  task automatic nvl(input logic [7:0] f, e);
    @(posedge clock_i);
    nv_flash_prot_byte_i <= f;
    nv_eeprom_prot_byte_i <= e;
    nv_load_i <= 1'b1;
    @(posedge clock_i);
    nv_load_i <= 1'b0;
  endtask
  // k = {block_erase, eeprom}
  task automatic cmd(input logic [1:0] k, input logic [15:0] a, input logic acc);
    @(posedge clock_i);
    cmd_i <= {1'b1, k, a};
    #1;
    chk(32'(cmd_accept_o), 32'(acc));
    @(posedge clock_i);
    cmd_i.valid <= 1'b0;
  endtask

  task automatic t_reset();
    rd(A_FP, `FLASH_PROT_RST);
    rd(A_EP, `EEPROM_PROT_RST);
    rd(A_ECC, 8'h00);
    rd(8'h3c, 8'h00, `AXI_RESP_SLVERR);
  endtask
  task automatic t_fault();
    arr(3'b100);
    rd(A_ECC, 8'h01);
    wr(A_ECC, 8'h00);
    rd(A_ECC, 8'h01);
    wr(A_ECC, 8'h01);
    rd(A_ECC, 8'h00);
    arr(3'b010);
    #1;
    chk(32'(double_fault_flag_o), 32'h0);
    @(posedge clock_i);
    #1;
    chk(32'(double_fault_flag_o), 32'h1);
    wr(A_ECC, 8'hfd);
    rd(A_ECC, 8'h02);
    wr(A_ECC, 8'h02);
    arr(3'b001);
    rd(A_ECC, 8'h03);
    wr(A_ECC, 8'h03);
    wr(A_CFG, 8'h01);
    arr(3'b100);
    arr(3'b001);
    rd(A_ECC, 8'h02);
    wr(A_ECC, 8'h03);
    wr(A_CFG, 8'h00);
  endtask
  task automatic t_flash();
    cmd(2'b00, 16'hc000, 1'b0);
    nvl(8'h80, 8'h80);
    rd(A_FP, 8'hc0);
    rd(A_EP, 8'h80);
    cmd(2'b00, 16'hfdff, 1'b0);
    wr(A_ST, 8'h00);
    chk(32'(cmd_seq_blocked_o), 32'h1);
    wr(A_ST, 8'h10);
    cmd(2'b00, 16'hfdff, 1'b1);
    cmd(2'b10, 16'hc000, 1'b0);
    wr(A_ST, 8'h10);
    wr(A_FP, 8'ha0);
    rd(A_FP, 8'hc0);
    wr(A_FP, 8'h98);
    rd(A_FP, 8'hc0);
    nvl(8'h00, 8'h80);
    cmd(2'b00, 16'hfe00, 1'b1);
    cmd(2'b00, 16'hfdff, 1'b0);
    wr(A_ST, 8'h10);
    nvl(8'ha0, 8'h80);
    wr(A_FP, 8'h98);
    rd(A_FP, 8'hd8);
    cmd(2'b00, 16'hefff, 1'b1);
    cmd(2'b00, 16'hf000, 1'b0);
    wr(A_ST, 8'h10);
  endtask
  task automatic t_eeprom();
    cmd(2'b11, 16'h0000, 1'b1);
    wr(A_EP, 8'h01);
    rd(A_EP, 8'h01);
    cmd(2'b11, 16'h0000, 1'b0);
    wr(A_ST, 8'h10);
    wr(A_EP, 8'h80);
    rd(A_EP, 8'h01);
    wr(A_EP, 8'h83);
    rd(A_EP, 8'h03);
    nvl(8'ha0, 8'h02);
    rd(A_EP, 8'h02);
  endtask
  task automatic wrap_up();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    {rst_n_i, nv_load_i, s_axil_awvalid_i, s_axil_wvalid_i, s_axil_bready_i} = '0;
    {s_axil_arvalid_i, s_axil_rready_i, s_axil_awaddr_i, s_axil_araddr_i} = '0;
    {nv_flash_prot_byte_i, nv_eeprom_prot_byte_i, s_axil_wdata_i, array_read_i, cmd_i} = '0;
    s_axil_wstrb_i = 4'h1;
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_reset();
    t_fault();
    t_flash();
    t_eeprom();
    wrap_up();
  end
endmodule
